/* logic/ilsp_ctrl.sv */
`default_nettype none

module ilsp_ctrl #(
    parameter int unsigned SEQ_FILTER = ilsp_pkg::SEQ_FILTER_CYC,
    parameter int unsigned NMI_PULSE  = ilsp_pkg::NMI_PULSE_CYC
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        clk_en,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ilsp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    output logic                             irq_o,
    // Instrument pins, asynchronous
    input  wire logic                        sequence_irq_n,
    input  wire logic                        key_irq_n,
    input  wire logic                        reverse_power_irq_n,
    input  wire ilsp_pkg::ilsp_stat_t        stat_in,
    input  wire logic                        nmi_abort_n,
    input  wire logic                        normal_position,
    // Processor side, same clock
    input  wire logic                        srr_rd_strobe,
    input  wire logic                        key_irq_clear,
    input  wire logic                        seq_irq_clear,
    output logic [7:0]                       srr_data_o,
    output logic                             srr_data_oe,
    output logic                             irq_n_o,
    output logic                             irq_n_oe,
    output logic                             nmi_n_o
);
    import ilsp_pkg::*;

    localparam logic [NMI_CNT_W-1:0] NMI_LEN = NMI_CNT_W'(NMI_PULSE);

    // ***********************************************************************
    // Input synchronizers
    // ***********************************************************************
    logic [SY_W-1:0] raw_async;
    logic [SY_W-1:0] sync1_ff;
    logic [SY_W-1:0] sync2_ff;

    always_comb begin
        raw_async            = SYNC_RST;
        raw_async[SRR_DBL]   = stat_in.doubler_irq_n;
        raw_async[SRR_SEQ]   = sequence_irq_n;
        raw_async[SRR_KEY]   = key_irq_n;
        raw_async[SRR_LF]    = stat_in.lf_loop_unlocked;
        raw_async[SRR_OVER]  = stat_in.over_mod_flag;
        raw_async[SRR_UNDER] = stat_in.under_mod_flag;
        raw_async[SRR_IBUS]  = stat_in.instr_bus_irq_n;
        raw_async[SRR_RPWR]  = reverse_power_irq_n;
        raw_async[SY_NMI]    = nmi_abort_n;
        raw_async[SY_NRM]    = normal_position;
    end

    // Only sync2_ff is read by logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end else if (clk_en) begin
            sync1_ff <= raw_async;
            sync2_ff <= sync1_ff;
        end
    end

    // ***********************************************************************
    // Debounce
    // ***********************************************************************
    logic seq_active;
    logic key_active;
    logic seq_active_d_ff;
    logic key_active_d_ff;
    logic seq_rise;
    logic key_rise;

    // Both edges of the sequence closure are filtered
    ilsp_debounce #(
        .LEAD_CYC  (SEQ_FILTER),
        .TRAIL_CYC (SEQ_FILTER),
        .W         (CNT_W)
    ) u_seq_dbnc (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .din     (~sync2_ff[SRR_SEQ]),
        .active  (seq_active)
    );

    // Keyboard: leading edge taken at once, release filtered
    ilsp_debounce #(
        .LEAD_CYC  (1),
        .TRAIL_CYC (SEQ_FILTER),
        .W         (CNT_W)
    ) u_key_dbnc (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .din     (~sync2_ff[SRR_KEY]),
        .active  (key_active)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_active_d_ff <= 1'b0;
            key_active_d_ff <= 1'b0;
        end else if (clk_en) begin
            seq_active_d_ff <= seq_active;
            key_active_d_ff <= key_active;
        end
    end

    assign seq_rise = seq_active & ~seq_active_d_ff;
    assign key_rise = key_active & ~key_active_d_ff;

    // ***********************************************************************
    // APB decode
    // ***********************************************************************
    logic       rdy_ff;
    logic       err_ff;
    logic [31:0] rdata_ff;
    logic       apb_done;
    logic       apb_wr;
    logic       mapped;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_mask;

    always_comb begin
        mapped = (paddr == OFS_CTRL) || (paddr == OFS_SRR) || (paddr == OFS_RAW)
              || (paddr == OFS_INT_STAT) || (paddr == OFS_INT_MASK);
    end

    assign apb_done = psel & penable & rdy_ff & clk_en;
    assign apb_wr   = apb_done & pwrite & ~err_ff;
    assign wr_ctrl  = apb_wr & (paddr == OFS_CTRL);
    assign wr_stat  = apb_wr & (paddr == OFS_INT_STAT);
    assign wr_mask  = apb_wr & (paddr == OFS_INT_MASK);
    assign pready   = rdy_ff & clk_en;
    assign pslverr  = pready & err_ff;
    assign prdata   = rdata_ff;

    // ***********************************************************************
    // Sequence and keyboard latches
    // ***********************************************************************
    logic seq_latch_ff;
    logic key_latch_ff;
    logic seq_clr;
    logic key_clr;

    assign seq_clr = seq_irq_clear | (wr_ctrl & pwdata[CTRL_SEQ_CLR_BIT]);
    assign key_clr = key_irq_clear | (wr_ctrl & pwdata[CTRL_KEY_CLR_BIT]);

    // Set wins over a clear in the same cycle so no closure is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_latch_ff <= 1'b0;
        end else if (clk_en) begin
            seq_latch_ff <= seq_rise | (seq_latch_ff & ~seq_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_latch_ff <= 1'b0;
        end else if (clk_en) begin
            key_latch_ff <= key_rise | (key_latch_ff & ~key_clr);
        end
    end

    // ***********************************************************************
    // Conditions, service register and events
    // ***********************************************************************
    logic [SRR_W-1:0] cond;
    logic [SRR_W-1:0] cond_d_ff;
    logic [SRR_W-1:0] event_set;
    logic [SRR_W-1:0] srr_ff;

    // Status lines keep their own polarity on the bus
    genvar gi;
    generate
        for (gi = 0; gi < SRR_W; gi++) begin : g_cond
            if (gi == SRR_SEQ) begin : g_seq
                assign cond[gi] = seq_latch_ff;
            end else if (gi == SRR_KEY) begin : g_key
                assign cond[gi] = key_latch_ff;
            end else begin : g_pin
                assign cond[gi] = sync2_ff[gi] ^ SRR_IDLE[gi];
            end
            assign event_set[gi] = cond[gi] & ~cond_d_ff[gi];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_d_ff <= '0;
            srr_ff    <= SRR_IDLE;
        end else if (clk_en) begin
            cond_d_ff <= cond;
            srr_ff    <= cond ^ SRR_IDLE;
        end
    end

    assign srr_data_o  = srr_ff;
    assign srr_data_oe = srr_rd_strobe;

    // ***********************************************************************
    // Maskable request
    // ***********************************************************************
    logic irq_n_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_n_ff <= 1'b1;
        end else if (clk_en) begin
            irq_n_ff <= ~(seq_latch_ff | key_latch_ff | ~sync2_ff[SRR_RPWR]);
        end
    end

    assign irq_n_o  = irq_n_ff;
    assign irq_n_oe = sync2_ff[SY_NRM];

    // ***********************************************************************
    // Non-maskable abort
    // ***********************************************************************
    logic                 nmi_prev_ff;
    logic [NMI_CNT_W-1:0] nmi_cnt_ff;
    logic                 nmi_trig;

    // Edge, not level: a grounded test point fires only once
    assign nmi_trig = (nmi_prev_ff & ~sync2_ff[SY_NMI])
                    | (wr_ctrl & pwdata[CTRL_NMI_BIT]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_prev_ff <= 1'b1;
        end else if (clk_en) begin
            nmi_prev_ff <= sync2_ff[SY_NMI];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_cnt_ff <= '0;
            nmi_n_o    <= 1'b1;
        end else if (clk_en) begin
            if (nmi_trig && (nmi_cnt_ff == '0)) begin
                nmi_cnt_ff <= NMI_LEN;
                nmi_n_o    <= 1'b0;
            end else if (nmi_cnt_ff > NMI_CNT_W'(1)) begin
                nmi_cnt_ff <= nmi_cnt_ff - NMI_CNT_W'(1);
            end else begin
                nmi_cnt_ff <= '0;
                nmi_n_o    <= 1'b1;
            end
        end
    end

    // ***********************************************************************
    // Interrupt status and mask
    // ***********************************************************************
    logic [SRR_W-1:0] int_stat_ff;
    logic [SRR_W-1:0] int_mask_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_ff <= '0;
        end else if (clk_en) begin
            // Write one clears, a new event in the same cycle stays
            int_stat_ff <= event_set
                         | (int_stat_ff & ~(wr_stat ? pwdata[SRR_W-1:0] : '0));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_ff <= INT_MASK_RST;
        end else if (clk_en && wr_mask) begin
            int_mask_ff <= pwdata[SRR_W-1:0];
        end
    end

    assign irq_o = |(int_stat_ff & int_mask_ff);

    // ***********************************************************************
    // APB response
    // ***********************************************************************
    // One wait state lets read data come from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_ff   <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= '0;
        end else if (clk_en) begin
            if (apb_done) begin
                rdy_ff   <= 1'b0;
                err_ff   <= 1'b0;
                rdata_ff <= '0;
            end else if (psel && penable && !rdy_ff) begin
                rdy_ff <= 1'b1;
                err_ff <= ~mapped;
                case (paddr)
                    OFS_SRR:      rdata_ff <= {24'h000000, srr_ff};
                    OFS_RAW:      rdata_ff <= {22'h0, sync2_ff};
                    OFS_INT_STAT: rdata_ff <= {24'h000000, int_stat_ff};
                    OFS_INT_MASK: rdata_ff <= {24'h000000, int_mask_ff};
                    default:      rdata_ff <= '0;
                endcase
            end
        end
    end

endmodule : ilsp_ctrl

`default_nettype wire

/* logic/ilsp_debounce.sv */
`default_nettype none

module ilsp_debounce #(
    parameter int unsigned LEAD_CYC  = 1,
    parameter int unsigned TRAIL_CYC = 1,
    parameter int unsigned W         = ilsp_pkg::CNT_W
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic din,
    output logic      active
);
    import ilsp_pkg::*;

    localparam logic [W-1:0] LEAD_M1  = W'(LEAD_CYC - 1);
    localparam logic [W-1:0] TRAIL_M1 = W'(TRAIL_CYC - 1);
    localparam logic [W-1:0] ONE      = W'(1);

    ilsp_dbnc_st_t st_ff;
    ilsp_dbnc_st_t nxt_st;
    logic [W-1:0]  cnt_ff;
    logic [W-1:0]  nxt_cnt;

    // ***********************************************************************
    // Next state
    // ***********************************************************************
    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            DB_OFF: begin
                if (din) begin
                    nxt_cnt = ONE;
                    nxt_st  = (LEAD_CYC <= 1) ? DB_ON : DB_RISE;
                end
            end
            DB_RISE: begin
                // A glitch restarts the wait
                if (!din) begin
                    nxt_st = DB_OFF;
                end else if (cnt_ff >= LEAD_M1) begin
                    nxt_st = DB_ON;
                end else begin
                    nxt_cnt = cnt_ff + ONE;
                end
            end
            DB_ON: begin
                if (!din) begin
                    nxt_cnt = ONE;
                    nxt_st  = (TRAIL_CYC <= 1) ? DB_OFF : DB_FALL;
                end
            end
            DB_FALL: begin
                if (din) begin
                    nxt_st = DB_ON;
                end else if (cnt_ff >= TRAIL_M1) begin
                    nxt_st = DB_OFF;
                end else begin
                    nxt_cnt = cnt_ff + ONE;
                end
            end
            default: begin
                nxt_st  = DB_OFF;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff  <= DB_OFF;
            cnt_ff <= '0;
            active <= 1'b0;
        end else if (clk_en) begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
            active <= (nxt_st == DB_ON) || (nxt_st == DB_FALL);
        end
    end

endmodule : ilsp_debounce

`default_nettype wire

/* logic/ilsp_pkg.sv */
// Functional notes
// - Low closure on the sequence input is an event held by a set-dominant latch.
// - Sequence assertion is accepted only after it stays low for 33 ms.
// - Sequence release is accepted only after it stays high for 33 ms.
// - Latched sequence, keyboard and reverse-power sources OR onto active-low request.
// - Maskable request is driven only in normal position, undriven in ROM test.
// - Sequence latch holds until processor clears it; clearing withdraws its request.
// - NMI line idles high; a short low pulse aborts to the NMI routine.
// - Service register puts two latched interrupts, reverse power and status lines on bus when strobed.
// - Status lines: LF unlock, over/under modulation high; bus and doubler low.
// - Keyboard latch is cleared by the keyboard clear strobe from address 01FB.
`default_nettype none

package ilsp_pkg;

    // ***********************************************************************
    // Timing
    // ***********************************************************************
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned SEQ_FILTER_MS  = 33;
    localparam int unsigned SEQ_FILTER_CYC = (SEQ_FILTER_MS * CLK_HZ + 999) / 1000;
    localparam int unsigned NMI_PULSE_NS   = 1000;
    localparam int unsigned NMI_PULSE_CYC  = (NMI_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CNT_W          = 20;
    localparam int unsigned NMI_CNT_W      = 8;

    // ***********************************************************************
    // Register map
    // ***********************************************************************
    localparam int unsigned ADDR_W       = 12;
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_SRR      = 12'h004;
    localparam logic [11:0] OFS_RAW      = 12'h008;
    localparam logic [11:0] OFS_INT_STAT = 12'h00c;
    localparam logic [11:0] OFS_INT_MASK = 12'h010;

    localparam int unsigned CTRL_NMI_BIT     = 0;
    localparam int unsigned CTRL_SEQ_CLR_BIT = 1;
    localparam int unsigned CTRL_KEY_CLR_BIT = 2;

    // Service register bit positions; sync vector shares 0..7
    localparam int unsigned SRR_DBL   = 0;
    localparam int unsigned SRR_SEQ   = 1;
    localparam int unsigned SRR_KEY   = 2;
    localparam int unsigned SRR_LF    = 3;
    localparam int unsigned SRR_OVER  = 4;
    localparam int unsigned SRR_UNDER = 5;
    localparam int unsigned SRR_IBUS  = 6;
    localparam int unsigned SRR_RPWR  = 7;
    localparam int unsigned SY_NMI    = 8;
    localparam int unsigned SY_NRM    = 9;
    localparam int unsigned SRR_W     = 8;
    localparam int unsigned SY_W      = 10;

    // Idle image: active-low bits read high
    localparam logic [7:0]  SRR_IDLE     = 8'hc7;
    localparam logic [9:0]  SYNC_RST     = 10'h1c7;
    localparam logic [7:0]  INT_MASK_RST = 8'h00;

    // ***********************************************************************
    // Types
    // ***********************************************************************
    typedef struct packed {
        logic lf_loop_unlocked;
        logic over_mod_flag;
        logic under_mod_flag;
        logic instr_bus_irq_n;
        logic doubler_irq_n;
    } ilsp_stat_t;

    typedef enum logic [3:0] {
        DB_OFF  = 4'b0001,
        DB_RISE = 4'b0010,
        DB_ON   = 4'b0100,
        DB_FALL = 4'b1000
    } ilsp_dbnc_st_t;

endpackage : ilsp_pkg

`default_nettype wire

/* testbench/ilsp_cpu_model.sv */
`default_nettype none

module ilsp_cpu_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       auto_en,
    input  wire logic       poll,
    input  wire logic       irq_line_n,
    input  wire logic [7:0] dbus,
    output logic            srr_rd_strobe,
    output logic            key_irq_clear,
    output logic            seq_irq_clear,
    output logic [7:0]      srr_seen_ff,
    output logic [7:0]      served_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] st_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff         <= 3'h0;
            srr_rd_strobe <= 1'b0;
            key_irq_clear <= 1'b0;
            seq_irq_clear <= 1'b0;
            srr_seen_ff   <= 8'hff;
            served_ff     <= 8'h00;
        end else begin
            key_irq_clear <= 1'b0;
            seq_irq_clear <= 1'b0;
            case (st_ff)
                3'h0: begin
                    // One idle state stands for finishing the current instruction
                    if (poll || (auto_en && !irq_line_n)) begin
                        st_ff <= 3'h1;
                    end
                end
                3'h1: begin
                    srr_rd_strobe <= 1'b1;
                    st_ff         <= 3'h2;
                end
                3'h2: begin
                    srr_rd_strobe <= 1'b0;
                    srr_seen_ff   <= dbus;
                    served_ff     <= served_ff + 8'h01;
                    st_ff         <= 3'h3;
                    // Reverse power is latched elsewhere, so it only blocks the rest
                    if (dbus[7]) begin
                        seq_irq_clear <= ~dbus[1];
                        key_irq_clear <= dbus[1] & ~dbus[2];
                    end
                end
                // Cool-down lets the cleared request reach the line before a new look
                default: st_ff <= st_ff + 3'h1;
            endcase
        end
    end
endmodule : ilsp_cpu_model

`default_nettype wire

/* testbench/ilsp_ctrl_sva.sv */
`default_nettype none

module ilsp_ctrl_sva
    import ilsp_pkg::*;
#(
    parameter int unsigned SEQ_FILTER = 8,
    parameter int unsigned NMI_PULSE  = 4
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       sequence_irq_n,
    input wire logic       key_irq_n,
    input wire logic       reverse_power_irq_n,
    input wire logic       normal_position,
    input wire logic       srr_rd_strobe,
    input wire logic       key_irq_clear,
    input wire logic       seq_irq_clear,
    input wire logic [7:0] srr_data_o,
    input wire logic       srr_data_oe,
    input wire logic       irq_n_o,
    input wire logic       irq_n_oe,
    input wire logic       nmi_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************
    // Run lengths
    // ****************
    logic [7:0] nmi_lo_ff;
    logic [7:0] seq_lo_ff;
    logic [7:0] key_hi_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_lo_ff <= 8'h00;
            seq_lo_ff <= 8'h00;
            key_hi_ff <= 8'h00;
        end else begin
            nmi_lo_ff <= nmi_n_o ? 8'h00 : nmi_lo_ff + 8'h01;
            seq_lo_ff <= sequence_irq_n ? 8'h00 : seq_lo_ff + 8'h01;
            // Saturates, since the key idles high for long spans
            key_hi_ff <= key_irq_n ? key_hi_ff + {7'h00, ~&key_hi_ff} : 8'h00;
        end
    end

    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    oe_on_a: assert property (normal_position [*3] |=> irq_n_oe)
        else $error("request driver off in normal position");
    oe_off_a: assert property (!normal_position [*3] |=> !irq_n_oe)
        else $error("request driven in test position");
    nmi_len_a: assert property ($rose(nmi_n_o) |-> nmi_lo_ff == 8'(NMI_PULSE))
        else $error("abort pulse length wrong");
    srr_oe_a: assert property (srr_data_oe == srr_rd_strobe)
        else $error("service bus enable not following strobe");
    seq_db_a: assert property (
        $fell(srr_data_o[SRR_SEQ]) |-> seq_lo_ff >= 8'(SEQ_FILTER))
        else $error("sequence accepted too early");
    seq_irq_a: assert property ($fell(srr_data_o[SRR_SEQ]) |-> ##[0:2] !irq_n_o)
        else $error("sequence latch not requesting");
    seq_hold_a: assert property (
        !srr_data_o[SRR_SEQ] && !seq_irq_clear && !$past(seq_irq_clear) && !psel
        && !$past(psel) |=> !srr_data_o[SRR_SEQ])
        else $error("sequence latch dropped without clear");
    key_clr_a: assert property (
        key_irq_clear && key_hi_ff > 8'(SEQ_FILTER + 6) |-> ##2 srr_data_o[SRR_KEY])
        else $error("keyboard latch not cleared");
    rpwr_req_a: assert property (!reverse_power_irq_n [*4] |=> !irq_n_o)
        else $error("reverse power not requesting");
endmodule : ilsp_ctrl_sva

`default_nettype wire

/* testbench/tb_irq_latch_status_poll.sv */
`default_nettype none

module tb_irq_latch_status_poll
    import ilsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned SEQ_F = 8;
    localparam int unsigned NMI_P = 4;
    localparam int          SB [5] = '{SRR_DBL, SRR_IBUS, SRR_UNDER, SRR_OVER, SRR_LF};

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_o, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sequence_irq_n, key_irq_n, reverse_power_irq_n, nmi_abort_n;
    logic        normal_position, srr_rd_strobe, key_irq_clear, seq_irq_clear;
    logic        srr_data_oe, irq_n_o, irq_n_oe, nmi_n_o, auto_en, poll;
    logic [7:0]  srr_data_o, srr_seen, served, n0;
    ilsp_stat_t  stat_in;
    int          mismatches, total_checks, cnt;
    wire logic [7:0] dbus;
    wire logic       irq_line_n;

    // Released lines: the request has a pull-up, the bus shows a toggling pattern
    assign irq_line_n = irq_n_oe ? irq_n_o : 1'b1;
    assign dbus       = srr_data_oe ? srr_data_o : {8{pclk}};

    ilsp_ctrl #(.SEQ_FILTER(SEQ_F), .NMI_PULSE(NMI_P)) u_ilsp_ctrl (
        .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq_o, .sequence_irq_n, .key_irq_n,
        .reverse_power_irq_n, .stat_in, .nmi_abort_n, .normal_position, .srr_rd_strobe,
        .key_irq_clear, .seq_irq_clear, .srr_data_o, .srr_data_oe, .irq_n_o, .irq_n_oe,
        .nmi_n_o
    );

    ilsp_cpu_model u_ilsp_cpu_model (
        .pclk, .presetn, .auto_en, .poll, .irq_line_n, .dbus, .srr_rd_strobe,
        .key_irq_clear, .seq_irq_clear, .srr_seen_ff(srr_seen), .served_ff(served)
    );

    // ****************
    // Tasks
    // ****************
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic poll_srr;
        poll <= 1'b1;
        tick(1);
        poll <= 1'b0;
        tick(10);
    endtask : poll_srr

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // ****************
    // Sequence
    // ****************
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // The run takes about 300 cycles; ten times that is a hang
    initial begin
        #(50 * 3000);
        mismatches++;
        test_done();
    end

    initial begin
        {psel, penable, pwrite, poll, auto_en, presetn} = '0;
        paddr = '0;
        pwdata = '0;
        {sequence_irq_n, key_irq_n, reverse_power_irq_n, nmi_abort_n, normal_position} = '1;
        stat_in = ilsp_stat_t'(5'h03);
        tick(2);
        presetn <= 1'b1;
        tick(4);
        chk(srr_data_o, SRR_IDLE);
        chk(nmi_n_o, 1'b1);
        chk(irq_n_oe, 1'b1);
        apb(1'b0, OFS_SRR, 32'h0);
        chk(rd, {24'h0, SRR_IDLE});
        apb(1'b0, OFS_INT_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFS_INT_MASK, 32'h08);
        for (int i = 0; i < 5; i++) begin
            stat_in <= ilsp_stat_t'(5'h03 ^ (5'h01 << i));
            tick(5);
            chk(srr_data_o, SRR_IDLE ^ (8'h01 << SB[i]));
            chk(irq_o, i == 4);
            poll_srr();
            chk(srr_seen, SRR_IDLE ^ (8'h01 << SB[i]));
        end
        stat_in <= ilsp_stat_t'(5'h03);
        tick(5);
        apb(1'b0, OFS_INT_STAT, 32'h0);
        chk(rd, 32'h79);
        apb(1'b1, OFS_INT_STAT, 32'h79);
        tick(1);
        chk(irq_o, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // Glitch shorter than the filter must not latch
        sequence_irq_n <= 1'b0;
        tick(SEQ_F - 2);
        sequence_irq_n <= 1'b1;
        tick(15);
        chk(srr_data_o, SRR_IDLE);
        normal_position <= 1'b0;
        auto_en <= 1'b1;
        n0 = served;
        sequence_irq_n <= 1'b0;
        tick(20);
        chk(irq_n_o, 1'b0);
        sequence_irq_n <= 1'b1;
        tick(20);
        chk(srr_data_o, 8'hc5);
        chk(irq_n_oe, 1'b0);
        chk(served, n0);
        normal_position <= 1'b1;
        tick(20);
        chk(srr_seen, 8'hc5);
        chk(srr_data_o, SRR_IDLE);
        chk(irq_n_o, 1'b1);
        auto_en <= 1'b0;
        reverse_power_irq_n <= 1'b0;
        key_irq_n <= 1'b0;
        tick(6);
        key_irq_n <= 1'b1;
        chk(irq_n_o, 1'b0);
        poll_srr();
        chk(srr_seen, 8'h43);
        chk(srr_data_o, 8'h43);
        reverse_power_irq_n <= 1'b1;
        tick(30);
        poll_srr();
        chk(srr_seen, 8'hc3);
        chk(srr_data_o, SRR_IDLE);
        chk(irq_n_o, 1'b1);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) begin
                nmi_abort_n <= 1'b0;
                tick(2);
                nmi_abort_n <= 1'b1;
            end else begin
                apb(1'b1, OFS_CTRL, 32'h1);
            end
            cnt = 0;
            repeat (20) begin
                tick(1);
                cnt += (nmi_n_o === 1'b0);
            end
            chk(cnt, NMI_P);
        end
        test_done();
    end
endmodule : tb_irq_latch_status_poll

bind ilsp_ctrl ilsp_ctrl_sva #(.SEQ_FILTER(SEQ_FILTER), .NMI_PULSE(NMI_PULSE)) u_ilsp_ctrl_sva (
    .pclk, .presetn, .psel, .sequence_irq_n, .key_irq_n, .reverse_power_irq_n,
    .normal_position, .srr_rd_strobe, .key_irq_clear, .seq_irq_clear, .srr_data_o,
    .srr_data_oe, .irq_n_o, .irq_n_oe, .nmi_n_o
);

`default_nettype wire
